// ==== dv/dpo_panel_model.sv ====
`timescale 1ns/100ps
module dpo_panel_model (
  output logic pixel_clock,
  input wire logic clk_oe_n,
  input wire logic dat_oe_n,
  output logic clk_line,
  output logic dat_line
);
  // Board pull-ups, so a released line reads high
  assign clk_line = clk_oe_n;
  assign dat_line = dat_oe_n;
  // Free-running, phase unrelated to the core clock
  initial begin
    pixel_clock = 1'b0;
    #7;
    forever #200 pixel_clock = ~pixel_clock;
  end
endmodule : dpo_panel_model

// ==== dv/tb_dpo_output_sequencer.sv ====
`timescale 1ns/100ps
module tb_dpo_output_sequencer;
  localparam int MS = 20;
  localparam int Q = dpo_pkg::DDC_QUARTER_CYCLES;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata, v, s;
  dpo_pkg::dpo_pixel_t pixel_in = '0;
  logic [7:0] dr, dg, db;
  logic [7:0] sy [3] = '{8'h03, 8'hc9, 8'h84};
  logic [3:0] pp, pn, pw;
  logic pck, hs, vs, oe_n, cm, lp, sup, bl, mcc, mcd, cc_oe_n, cd_oe_n, z;
  int miscompares = 0;
  int n_compared = 0;
  int t;
  assign pw = {mcc, bl, ~lp, sup};
  always #25 core_clk = ~core_clk;
  dpo_output_sequencer #(.MS_CYCLES(MS)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pixel_clock(pck), .pixel_in(pixel_in),
    .dac_red(dr), .dac_green(dg), .dac_blue(db), .crt_hsync(hs),
    .crt_vsync(vs), .lvds_p(pp), .lvds_n(pn), .lvds_oe_n(oe_n),
    .lvds_common_mode(cm), .lvds_low_power(lp),
    .panel_supply_enable(sup), .backlight_enable(bl),
    .monitor_channel_clock_in(mcc), .monitor_channel_clock_out(),
    .monitor_channel_clock_oe_n(cc_oe_n),
    .monitor_channel_data_in(mcd), .monitor_channel_data_out(),
    .monitor_channel_data_oe_n(cd_oe_n));
  dpo_panel_model i_panel (.pixel_clock(pck), .clk_oe_n(cc_oe_n),
    .dat_oe_n(cd_oe_n), .clk_line(mcc), .dat_line(mcd));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic await(input int k, input logic e);
    while (pw[k] !== e && t < 20000) begin
      @(posedge core_clk);
      #1;
      t++;
    end
    if (t >= 20000) miscompares++;
  endtask : await
  task automatic lane(input logic [15:0] m, input logic [31:0] k, e);
    wr(dpo_pkg::ADDR_LANE_CTRL, m);
    repeat (24) @(posedge core_clk);
    #1;
    check(32'({oe_n, lp, cm, pp, pn}) & k, e);
  endtask : lane
  // Two pixel periods of 8 core cycles: clock lane must be a rotation
  task automatic lanes(input logic e);
    logic [7:0] p;
    logic hit;
    p = {dpo_pkg::CLK_PATTERN, dpo_pkg::CLK_PATTERN[0]};
    hit = 1'b0;
    z = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk);
      #1;
      s = {s[14:0], pp[3]};
      z |= |pp[1:0];
    end
    for (int r = 0; r < 8; r++)
      hit |= (s === {2{8'({p, p} >> r)}});
    check(32'({hit, z}), 32'({1'b1, e}));
  endtask : lanes
  initial begin
    #2000000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    check(32'({hs, vs, sup, bl, oe_n, lp}), 32'h33);
    wr(dpo_pkg::ADDR_POWER_CYCLE, 16'h0005);
    rd(dpo_pkg::ADDR_SYNC_CTRL, v);
    check(32'(v), 32'h24);
    rd(4'hf, v);
    check(32'(v), 32'h0);
    pixel_in <= '{8'ha5, 8'h3c, 8'h81, 1'b1, 1'b1, 1'b0};
    foreach (sy[i]) begin
      wr(dpo_pkg::ADDR_SYNC_CTRL, 16'(sy[i][5:0]));
      repeat (24) @(posedge core_clk);
      #1;
      check(32'({hs, vs}), 32'(sy[i][7:6]));
    end
    check(32'({dr, dg, db}), 32'ha53c81);
    lane(16'h0004, 32'h7ff, 32'h600);
    wr(dpo_pkg::ADDR_SUPPLY_TO_LANES, 16'h0003);
    wr(dpo_pkg::ADDR_LANES_TO_BACKLIGHT, 16'h0001);
    wr(dpo_pkg::ADDR_LANES_OFF_TO_SUPPLY, 16'h0002);
    wr(dpo_pkg::ADDR_PANEL_CTRL, 16'h0001);
    t = 0;
    await(0, 1'b1);
    t = 0;
    await(1, 1'b1);
    check(32'(t inside {[12*MS+2:13*MS+2]}), 32'h1);
    t = 0;
    await(2, 1'b1);
    check(32'(t inside {[200*MS:201*MS+2]}), 32'h1);
    lanes(1'b1);
    pixel_in <= '{8'hff, 8'hff, 8'hff, 1'b0, 1'b0, 1'b1};
    lane(16'h0003, 32'h700, 32'h0);
    lanes(1'b0);
    lane(16'h0000, 32'h600, 32'h600);
    lane(16'h0001, 32'h7ff, 32'h200);
    lane(16'h0002, 32'h7ff, 32'h100);
    lane(16'h0004, 32'h700, 32'h0);
    wr(dpo_pkg::ADDR_PANEL_CTRL, 16'h0000);
    t = 0;
    await(2, 1'b0);
    t = 0;
    await(1, 1'b0);
    check(32'(t inside {[1:2*MS]}), 32'h1);
    t = 0;
    await(0, 1'b0);
    check(32'(t inside {[2*MS-2:3*MS]}), 32'h1);
    rd(dpo_pkg::ADDR_STATUS, v);
    check(32'(v), 32'h40);
    wr(dpo_pkg::ADDR_PANEL_CTRL, 16'h0001);
    t = 0;
    await(0, 1'b1);
    check(32'(t inside {[5*MS-8:6*MS]}), 32'h1);
    wr(dpo_pkg::ADDR_DDC_CTRL, 16'ha007);
    await(3, 1'b0);
    await(3, 1'b1);
    t = 0;
    await(3, 1'b0);
    await(3, 1'b1);
    check(32'(t inside {[4*Q-2:4*Q+4]}), 32'h1);
    do begin
      repeat (100) @(posedge core_clk);
      rd(dpo_pkg::ADDR_DDC_STATUS, v);
    end while (v[0] === 1'b1);
    check(32'(v[2:0]), 32'h6);
    conclude();
  end
endmodule : tb_dpo_output_sequencer

// ==== rtl/dpo_lane_serializer.sv ====
`timescale 1ns/100ps
module dpo_lane_serializer (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [dpo_pkg::DATA_LANES*dpo_pkg::LANE_BITS-1:0] word,
  output logic [dpo_pkg::DATA_LANES:0] ser_bits
);
  logic [dpo_pkg::DATA_LANES*dpo_pkg::LANE_BITS-1:0] sh_data;
  logic [dpo_pkg::LANE_BITS-1:0] sh_clk;
  logic [2:0] left;

  // Last bit stretches until the next pixel edge
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_data <= '0;
      sh_clk <= '0;
      left <= 3'h0;
    end else if (load) begin
      sh_data <= word;
      sh_clk <= dpo_pkg::CLK_PATTERN;
      left <= 3'h6;
    end else if (left != 3'h0) begin
      for (int i = 0; i < dpo_pkg::DATA_LANES; i++) begin
        sh_data[i*7 +: 7] <= {sh_data[i*7 +: 6], 1'b0};
      end
      sh_clk <= {sh_clk[5:0], 1'b0};
      left <= left - 3'h1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < dpo_pkg::DATA_LANES; g++) begin : g_lane
      assign ser_bits[g] = sh_data[g*7 + 6];
    end
  endgenerate
  assign ser_bits[dpo_pkg::DATA_LANES] = sh_clk[6];

  sequence clk_pattern_s;
    ser_bits[3] ##1 ser_bits[3] ##1 !ser_bits[3] ##1 !ser_bits[3]
      ##1 !ser_bits[3] ##1 ser_bits[3] ##1 ser_bits[3];
  endsequence

  clk_lane_pattern_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    load |=> clk_pattern_s)
    else $error("clock lane pattern wrong");

  lane_align_a: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    load |=> ser_bits[0] == $past(word[6]) && ser_bits[3])
    else $error("data lane not aligned to clock lane");
endmodule : dpo_lane_serializer

// ==== rtl/dpo_output_sequencer.sv ====
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/100ps
module dpo_output_sequencer #(
  parameter int MS_CYCLES = dpo_pkg::MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [dpo_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [dpo_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [dpo_pkg::DATA_W-1:0] reg_rdata,
  input wire logic pixel_clock,
  input wire dpo_pkg::dpo_pixel_t pixel_in,
  output logic [7:0] dac_red,
  output logic [7:0] dac_green,
  output logic [7:0] dac_blue,
  output logic crt_hsync,
  output logic crt_vsync,
  output logic [dpo_pkg::DATA_LANES:0] lvds_p,
  output logic [dpo_pkg::DATA_LANES:0] lvds_n,
  output logic lvds_oe_n,
  output logic lvds_common_mode,
  output logic lvds_low_power,
  output logic panel_supply_enable,
  output logic backlight_enable,
  input wire logic monitor_channel_clock_in,
  output logic monitor_channel_clock_out,
  output logic monitor_channel_clock_oe_n,
  input wire logic monitor_channel_data_in,
  output logic monitor_channel_data_out,
  output logic monitor_channel_data_oe_n
);
  localparam int SYNC_W = $bits(dpo_pkg::dpo_pixel_t) + 3;

  logic [SYNC_W-1:0] in_meta, in_sync;
  dpo_pkg::dpo_pixel_t pix;
  logic pclk_s, pclk_d, pix_edge, scl_in, sda_in, vs_prev;
  dpo_pkg::dpo_sync_ctrl_t sync_ctrl;
  logic [2:0] lane_sel, eff_mode;
  logic power_req, h_over, v_over;
  logic [9:0] t2, t3, t4, t5, tgt, ms_cnt, lanes_ms, off_ms;
  logic [10:0] h_cnt, v_cnt;
  logic [15:0] ms_div, ddc1_shift;
  logic ms_tick, lanes_on, sync_written;
  dpo_pkg::dpo_seq_t seq, next_seq;
  logic [20:0] lane_word;
  logic [3:0] ser_bits;
  logic [5:0] r6, g6, b6;

  // Pins settle through two flops before any logic looks at them
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_meta <= '0;
      in_sync <= '0;
    end else begin
      in_meta <= {pixel_clock, monitor_channel_clock_in,
                  monitor_channel_data_in, pixel_in};
      in_sync <= in_meta;
    end
  end
  assign {pclk_s, scl_in, sda_in, pix} = in_sync;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pclk_d <= 1'b0;
    end else begin
      pclk_d <= pclk_s;
    end
  end
  assign pix_edge = pclk_s & ~pclk_d;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_div <= '0;
    end else if (ms_div == 16'(MS_CYCLES - 1)) begin
      ms_div <= '0;
    end else begin
      ms_div <= ms_div + 16'h0001;
    end
  end
  assign ms_tick = (ms_div == 16'(MS_CYCLES - 1));

  // Register writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_ctrl <= dpo_pkg::SYNC_RESET;
      lane_sel <= dpo_pkg::LANE_PD_TRI;
      power_req <= 1'b0;
      t2 <= dpo_pkg::SUPPLY_TO_LANES_RST;
      t3 <= dpo_pkg::LANES_OFF_TO_SUPPLY_RST;
      t4 <= dpo_pkg::POWER_CYCLE_RST;
      t5 <= dpo_pkg::LANES_TO_BACKLIGHT_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        dpo_pkg::ADDR_SYNC_CTRL: sync_ctrl <= reg_wdata[5:0];
        dpo_pkg::ADDR_LANE_CTRL: lane_sel <= reg_wdata[2:0];
        dpo_pkg::ADDR_PANEL_CTRL: power_req <= reg_wdata[0];
        dpo_pkg::ADDR_SUPPLY_TO_LANES: t2 <= reg_wdata[9:0];
        dpo_pkg::ADDR_LANES_OFF_TO_SUPPLY: t3 <= reg_wdata[9:0];
        dpo_pkg::ADDR_POWER_CYCLE: t4 <= reg_wdata[9:0];
        dpo_pkg::ADDR_LANES_TO_BACKLIGHT: t5 <= reg_wdata[9:0];
        default: ;
      endcase
    end
  end

  // Colour and enabled sync outputs, captured once per pixel clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_red <= '0;
      dac_green <= '0;
      dac_blue <= '0;
    end else if (pix_edge) begin
      dac_red <= pix.red;
      dac_green <= pix.green;
      dac_blue <= pix.blue;
    end
  end

  // Two independent wires; no composite or sync-on-green path exists
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      crt_hsync <= 1'b1;
      crt_vsync <= 1'b1;
    end else begin
      if (!sync_ctrl.hs_en) begin
        crt_hsync <= sync_ctrl.hs_park;
      end else if (pix_edge) begin
        crt_hsync <= pix.hsync ^ sync_ctrl.hs_inv;
      end
      if (!sync_ctrl.vs_en) begin
        crt_vsync <= sync_ctrl.vs_park;
      end else if (pix_edge) begin
        crt_vsync <= pix.vsync ^ sync_ctrl.vs_inv;
      end
    end
  end

  // Active size check against the largest supported format
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      h_cnt <= '0;
      v_cnt <= '0;
      vs_prev <= 1'b0;
      h_over <= 1'b0;
      v_over <= 1'b0;
      ddc1_shift <= '0;
    end else begin
      if (pix_edge) begin
        vs_prev <= pix.vsync;
        h_cnt <= pix.de ? h_cnt + 11'h001 : 11'h000;
        if (pix.vsync && !vs_prev) begin
          v_cnt <= '0;
          ddc1_shift <= {ddc1_shift[14:0], sda_in};
        end else if (!pix.de && h_cnt != 11'h000) begin
          v_cnt <= v_cnt + 11'h001;
        end
      end
      // Set wins over a clear in the same cycle
      if (pix_edge && pix.de && h_cnt >= dpo_pkg::MAX_H_ACTIVE) begin
        h_over <= 1'b1;
      end else if (reg_wr && reg_addr == dpo_pkg::ADDR_STATUS &&
                   reg_wdata[dpo_pkg::STAT_H_OVER]) begin
        h_over <= 1'b0;
      end
      if (v_cnt > dpo_pkg::MAX_V_ACTIVE) begin
        v_over <= 1'b1;
      end else if (reg_wr && reg_addr == dpo_pkg::ADDR_STATUS &&
                   reg_wdata[dpo_pkg::STAT_V_OVER]) begin
        v_over <= 1'b0;
      end
    end
  end

  // Panel power sequencer
  always_comb begin
    case (seq)
      dpo_pkg::SEQ_CYCLE: tgt = (t4 > dpo_pkg::POWER_CYCLE_MAX) ?
        dpo_pkg::POWER_CYCLE_MAX : t4;
      dpo_pkg::SEQ_SUPPLY: tgt = dpo_pkg::VDD_ON_MS;
      dpo_pkg::SEQ_LANES_WAIT: tgt = (t2 > dpo_pkg::SUPPLY_TO_LANES_MAX) ?
        dpo_pkg::SUPPLY_TO_LANES_MAX : t2;
      dpo_pkg::SEQ_BL_WAIT: tgt = (t5 < dpo_pkg::BL_MIN_MS) ?
        dpo_pkg::BL_MIN_MS : t5;
      dpo_pkg::SEQ_BL_OFF: tgt = dpo_pkg::BL_TO_LANES_MS;
      dpo_pkg::SEQ_LANES_OFF: tgt = (t3 > dpo_pkg::LANES_OFF_TO_SUPPLY_MAX) ?
        dpo_pkg::LANES_OFF_TO_SUPPLY_MAX : t3;
      default: tgt = '0;
    endcase
  end

  always_comb begin
    next_seq = seq;
    case (seq)
      dpo_pkg::SEQ_OFF: if (power_req) next_seq = dpo_pkg::SEQ_SUPPLY;
      dpo_pkg::SEQ_CYCLE: if (ms_cnt >= tgt) begin
        next_seq = dpo_pkg::SEQ_OFF;
      end
      dpo_pkg::SEQ_SUPPLY, dpo_pkg::SEQ_LANES_WAIT,
      dpo_pkg::SEQ_BL_WAIT: begin
        if (!power_req) begin
          next_seq = dpo_pkg::SEQ_BL_OFF;
        end else if (ms_cnt >= tgt) begin
          next_seq = dpo_pkg::dpo_seq_t'(seq + 3'h1);
        end
      end
      dpo_pkg::SEQ_ON: if (!power_req) next_seq = dpo_pkg::SEQ_BL_OFF;
      dpo_pkg::SEQ_BL_OFF: if (ms_cnt >= tgt) begin
        next_seq = dpo_pkg::SEQ_LANES_OFF;
      end
      dpo_pkg::SEQ_LANES_OFF: if (ms_cnt >= tgt) begin
        next_seq = dpo_pkg::SEQ_CYCLE;
      end
      default: next_seq = dpo_pkg::SEQ_CYCLE;
    endcase
  end

  // Reset starts in the cycle wait: the panel may have just lost power
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq <= dpo_pkg::SEQ_CYCLE;
      ms_cnt <= '0;
      panel_supply_enable <= 1'b0;
      lanes_on <= 1'b0;
      backlight_enable <= 1'b0;
    end else begin
      seq <= next_seq;
      if (next_seq != seq) begin
        ms_cnt <= '0;
      end else if (ms_tick && ms_cnt != 10'h3ff) begin
        ms_cnt <= ms_cnt + 10'h001;
      end
      panel_supply_enable <= next_seq inside {dpo_pkg::SEQ_SUPPLY,
        dpo_pkg::SEQ_LANES_WAIT, dpo_pkg::SEQ_BL_WAIT, dpo_pkg::SEQ_ON,
        dpo_pkg::SEQ_BL_OFF, dpo_pkg::SEQ_LANES_OFF};
      lanes_on <= next_seq inside {dpo_pkg::SEQ_BL_WAIT, dpo_pkg::SEQ_ON,
        dpo_pkg::SEQ_BL_OFF};
      // One cycle late: lane pins lag lanes_on, so the full gap holds
      backlight_enable <= (seq == dpo_pkg::SEQ_ON) &&
        (next_seq == dpo_pkg::SEQ_ON);
    end
  end

  // LVDS lanes: sequencer gates the software-chosen state
  assign eff_mode = lanes_on ? lane_sel :
    (lane_sel == dpo_pkg::LANE_PD_ZERO) ? dpo_pkg::LANE_PD_ZERO :
    dpo_pkg::LANE_PD_TRI;
  assign r6 = (eff_mode == dpo_pkg::LANE_ZEROS) ? 6'h00 : pix.red[7:2];
  assign g6 = (eff_mode == dpo_pkg::LANE_ZEROS) ? 6'h00 : pix.green[7:2];
  assign b6 = (eff_mode == dpo_pkg::LANE_ZEROS) ? 6'h00 : pix.blue[7:2];
  assign lane_word = {pix.de, pix.vsync, pix.hsync, b6[5:2],
                      b6[1:0], g6[5:1], g6[0], r6};

  dpo_lane_serializer u_ser (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .load(pix_edge),
    .word(lane_word),
    .ser_bits(ser_bits)
  );

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lvds_p <= '0;
      lvds_n <= '0;
      lvds_oe_n <= 1'b1;
      lvds_common_mode <= 1'b0;
      lvds_low_power <= 1'b1;
    end else begin
      case (eff_mode)
        dpo_pkg::LANE_ACTIVE, dpo_pkg::LANE_ZEROS: begin
          lvds_p <= ser_bits;
          lvds_n <= ~ser_bits;
          lvds_oe_n <= 1'b0;
          lvds_common_mode <= 1'b0;
          lvds_low_power <= 1'b0;
        end
        dpo_pkg::LANE_COMMON: begin
          lvds_p <= '0;
          lvds_n <= '0;
          lvds_oe_n <= 1'b0;
          lvds_common_mode <= 1'b1;
          lvds_low_power <= 1'b0;
        end
        dpo_pkg::LANE_PD_ZERO: begin
          lvds_p <= '0;
          lvds_n <= '0;
          lvds_oe_n <= 1'b0;
          lvds_common_mode <= 1'b0;
          lvds_low_power <= 1'b1;
        end
        default: begin
          lvds_p <= '0;
          lvds_n <= '0;
          lvds_oe_n <= 1'b1;
          lvds_common_mode <= 1'b0;
          lvds_low_power <= 1'b1;
        end
      endcase
    end
  end

  // Monitor channel byte engine, open drain, four phases per bit
  dpo_pkg::dpo_ddc_t ddc;
  logic [5:0] q_cnt;
  logic [1:0] ph;
  logic [3:0] bit_cnt;
  logic [8:0] tx, rx;
  logic p_xfer, p_stop, scl_low, sda_low, adv;

  assign adv = (q_cnt == 6'(dpo_pkg::DDC_QUARTER_CYCLES - 1)) &&
               !(ph == 2'h1 && !scl_low && !scl_in);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ddc <= dpo_pkg::DDC_IDLE;
      q_cnt <= '0;
      ph <= 2'h0;
      bit_cnt <= 4'h0;
      tx <= '1;
      rx <= '0;
      p_xfer <= 1'b0;
      p_stop <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
    end else if (ddc == dpo_pkg::DDC_IDLE) begin
      q_cnt <= '0;
      ph <= 2'h0;
      bit_cnt <= 4'h0;
      if (reg_wr && reg_addr == dpo_pkg::ADDR_DDC_CTRL) begin
        tx <= reg_wdata[2] ? {reg_wdata[15:8], 1'b1} :
                             {8'hff, ~reg_wdata[4]};
        p_xfer <= reg_wdata[2] | reg_wdata[3];
        p_stop <= reg_wdata[1];
        if (reg_wdata[0]) ddc <= dpo_pkg::DDC_START;
        else if (reg_wdata[2] | reg_wdata[3]) ddc <= dpo_pkg::DDC_BIT;
        else if (reg_wdata[1]) ddc <= dpo_pkg::DDC_STOP;
      end
    end else begin
      q_cnt <= (q_cnt == 6'(dpo_pkg::DDC_QUARTER_CYCLES - 1)) ? 6'h00 :
               q_cnt + 6'h01;
      if (adv) begin
        ph <= ph + 2'h1;
        case (ddc)
          dpo_pkg::DDC_START: case (ph)
            2'h0: begin
              sda_low <= 1'b0;
              scl_low <= 1'b0;
            end
            2'h1: sda_low <= 1'b1;
            2'h2: scl_low <= 1'b1;
            default: ddc <= p_xfer ? dpo_pkg::DDC_BIT :
                            p_stop ? dpo_pkg::DDC_STOP : dpo_pkg::DDC_IDLE;
          endcase
          dpo_pkg::DDC_BIT: case (ph)
            2'h0: sda_low <= ~tx[8];
            2'h1: scl_low <= 1'b0;
            2'h2: rx <= {rx[7:0], sda_in};
            default: begin
              scl_low <= 1'b1;
              tx <= {tx[7:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                p_xfer <= 1'b0;
                ddc <= p_stop ? dpo_pkg::DDC_STOP : dpo_pkg::DDC_IDLE;
              end
            end
          endcase
          default: case (ph)
            2'h0: sda_low <= 1'b1;
            2'h1: scl_low <= 1'b0;
            2'h2: sda_low <= 1'b0;
            default: begin
              p_stop <= 1'b0;
              ddc <= dpo_pkg::DDC_IDLE;
            end
          endcase
        endcase
      end
    end
  end

  assign monitor_channel_clock_out = 1'b0;
  assign monitor_channel_data_out = 1'b0;
  assign monitor_channel_clock_oe_n = ~scl_low;
  assign monitor_channel_data_oe_n = ~sda_low;

  // Read data stand for exactly the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        dpo_pkg::ADDR_SYNC_CTRL: reg_rdata <= {10'h000, sync_ctrl};
        dpo_pkg::ADDR_LANE_CTRL: reg_rdata <= {13'h0, lane_sel};
        dpo_pkg::ADDR_PANEL_CTRL: reg_rdata <= {15'h0, power_req};
        dpo_pkg::ADDR_SUPPLY_TO_LANES: reg_rdata <= {6'h00, t2};
        dpo_pkg::ADDR_LANES_OFF_TO_SUPPLY: reg_rdata <= {6'h00, t3};
        dpo_pkg::ADDR_POWER_CYCLE: reg_rdata <= {6'h00, t4};
        dpo_pkg::ADDR_LANES_TO_BACKLIGHT: reg_rdata <= {6'h00, t5};
        dpo_pkg::ADDR_STATUS: reg_rdata <= {7'h00, seq, v_over, h_over,
          backlight_enable, lanes_on, panel_supply_enable, 1'b0};
        dpo_pkg::ADDR_DDC_STATUS: reg_rdata <= {rx[8:1], 5'h00,
          scl_in, rx[0], ddc != dpo_pkg::DDC_IDLE};
        dpo_pkg::ADDR_DDC1_DATA: reg_rdata <= ddc1_shift;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // Checking helpers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lanes_ms <= '0;
      off_ms <= '0;
      sync_written <= 1'b0;
    end else begin
      lanes_ms <= !lanes_on ? 10'h000 :
        (ms_tick && lanes_ms != 10'h3ff) ? lanes_ms + 10'h001 : lanes_ms;
      off_ms <= panel_supply_enable ? 10'h000 :
        (ms_tick && off_ms != 10'h3ff) ? off_ms + 10'h001 : off_ms;
      if (reg_wr && reg_addr == dpo_pkg::ADDR_SYNC_CTRL) sync_written <= 1'b1;
    end
  end

  default clocking dpo_cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sync_park_a: assert property (!sync_ctrl.hs_en ##1 !sync_ctrl.hs_en
    |-> crt_hsync == $past(sync_ctrl.hs_park))
    else $error("hsync not parked");
  sync_reset_a: assert property (!sync_written
    |-> crt_hsync && crt_vsync) else $error("sync not high after reset");
  bl_delay_a: assert property ($rose(backlight_enable)
    |-> lanes_ms >= dpo_pkg::BL_MIN_MS) else $error("backlight too early");
  bl_first_a: assert property ($fell(lanes_on)
    |-> !backlight_enable) else $error("lanes stopped under backlight");
  supply_last_a: assert property ($fell(panel_supply_enable)
    |-> !lanes_on && !backlight_enable) else $error("supply dropped early");
  cycle_wait_a: assert property ($rose(panel_supply_enable)
    |-> off_ms >= t4 || t4 > dpo_pkg::POWER_CYCLE_MAX)
    else $error("power-up before cycle delay");
  lanes_pd_a: assert property (!lanes_on ##1 !lanes_on
    |-> lvds_low_power && lvds_p == '0 && lvds_n == '0)
    else $error("lanes live while powered down");
  zeros_blank_a: assert property (pix_edge && eff_mode == dpo_pkg::LANE_ZEROS
    |-> lane_word[17:0] == '0) else $error("colour leaked");
endmodule : dpo_output_sequencer

// ==== rtl/dpo_pkg.sv ====
package dpo_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DDC_RATE_HZ = 100000;
  localparam int DDC_QUARTER_NS = 1000000000 / (DDC_RATE_HZ * 4);
  localparam int DDC_QUARTER_CYCLES =
    (DDC_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] ADDR_SYNC_CTRL = 4'h0;
  localparam logic [3:0] ADDR_LANE_CTRL = 4'h1;
  localparam logic [3:0] ADDR_PANEL_CTRL = 4'h2;
  localparam logic [3:0] ADDR_SUPPLY_TO_LANES = 4'h3;
  localparam logic [3:0] ADDR_LANES_OFF_TO_SUPPLY = 4'h4;
  localparam logic [3:0] ADDR_POWER_CYCLE = 4'h5;
  localparam logic [3:0] ADDR_LANES_TO_BACKLIGHT = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_DDC_CTRL = 4'h8;
  localparam logic [3:0] ADDR_DDC_STATUS = 4'h9;
  localparam logic [3:0] ADDR_DDC1_DATA = 4'ha;

  // Sync control bits 5..0: vs_park vs_inv vs_en hs_park hs_inv hs_en
  localparam logic [5:0] SYNC_RESET = 6'h24;
  localparam int STAT_H_OVER = 4;
  localparam int STAT_V_OVER = 5;

  localparam logic [2:0] LANE_PD_TRI = 3'h0;
  localparam logic [2:0] LANE_PD_ZERO = 3'h1;
  localparam logic [2:0] LANE_COMMON = 3'h2;
  localparam logic [2:0] LANE_ZEROS = 3'h3;
  localparam logic [2:0] LANE_ACTIVE = 3'h4;

  localparam int LANE_BITS = 7;
  localparam int DATA_LANES = 3;
  localparam logic [6:0] CLK_PATTERN = 7'h63;

  localparam int MS_W = 10;
  localparam logic [9:0] VDD_ON_MS = 10'h00a;
  localparam logic [9:0] BL_MIN_MS = 10'h0c8;
  localparam logic [9:0] BL_TO_LANES_MS = 10'h001;
  localparam logic [9:0] SUPPLY_TO_LANES_MAX = 10'h032;
  localparam logic [9:0] LANES_OFF_TO_SUPPLY_MAX = 10'h032;
  localparam logic [9:0] POWER_CYCLE_MAX = 10'h190;
  localparam logic [9:0] SUPPLY_TO_LANES_RST = 10'h032;
  localparam logic [9:0] LANES_OFF_TO_SUPPLY_RST = 10'h032;
  localparam logic [9:0] POWER_CYCLE_RST = 10'h190;
  localparam logic [9:0] LANES_TO_BACKLIGHT_RST = 10'h0c8;

  localparam logic [10:0] MAX_H_ACTIVE = 11'h578;
  localparam logic [10:0] MAX_V_ACTIVE = 11'h41a;
  localparam int MAX_REFRESH_HZ = 60;

  typedef struct packed {
    logic vs_park;
    logic vs_inv;
    logic vs_en;
    logic hs_park;
    logic hs_inv;
    logic hs_en;
  } dpo_sync_ctrl_t;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
    logic hsync;
    logic vsync;
    logic de;
  } dpo_pixel_t;

  typedef enum logic [2:0] {
    SEQ_OFF, SEQ_CYCLE, SEQ_SUPPLY, SEQ_LANES_WAIT,
    SEQ_BL_WAIT, SEQ_ON, SEQ_BL_OFF, SEQ_LANES_OFF
  } dpo_seq_t;

  typedef enum logic [1:0] {
    DDC_IDLE, DDC_START, DDC_BIT, DDC_STOP
  } dpo_ddc_t;
endpackage : dpo_pkg
